// ---- core/i2crc_top.sv ----
// Purpose: role decode, master addressing and slave address match
// Assumes: a line engine outside performs the bit timing of master transfers
// Notes: link pins are sampled through two flip-flops before use
`timescale 1ns/1ns
module i2crc_top
  import i2crc_pkg::*;
#(
  parameter bit LIVE_TGT = 1'b1 // target carries its own width bit
) (
  input logic clock, // 125 MHz system clock
  input logic nrst, // synchronous reset, low active
  input logic [7:0] addr, // register byte offset
  input logic [31:0] wdata, // write data
  input logic wr, // write strobe
  input logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after strobe
  output logic mst_go, // pulse: line engine opens an address phase
  output logic mst_restart, // address phase uses repeated start
  output logic [9:0] mst_addr, // address for the line engine
  output logic mst_wide, // 10-bit address phase
  output logic mst_read, // direction of the transfer
  output i2crc_kind_t mst_kind, // normal, general call or start byte
  output logic mst_push, // pulse: one accepted data command
  output logic [7:0] mst_data, // data byte of that command
  output logic mst_stop, // stop after that byte
  output logic [1:0] mst_speed, // speed code for master timing
  output logic slv_hit, // pulse: own address matched
  output logic slv_read, // direction asked by remote master
  input logic scl_in, // clock line level
  input logic sda_in, // data line level
  output logic sda_out, // data line drive value
  output logic sda_oe // data line drive enable
);
  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  logic [10:0] ctrl;
  logic [12:0] tgt;
  logic [9:0] own;
  logic enable;
  logic abort;
  logic open;
  logic last_rd;

  // write decode
  wire wr_ctrl = wr && addr == A_CTRL;
  wire wr_tgt = wr && addr == A_TGT;
  wire wr_own = wr && addr == A_OWN;
  wire wr_ena = wr && addr == A_ENA;
  wire wr_raw = wr && addr == A_RAW;
  wire cmd_wr = wr && addr == A_CMD;

  // speed correction on write
  wire [1:0] wr_spd = wdata[B_SPD+1:B_SPD];
  wire spd_ok = wr_spd == SPD_STD || wr_spd == SPD_FAST;
  wire [1:0] next_spd = spd_ok ? wr_spd : SPD_FAST;
  wire [10:0] next_ctrl = {wdata[10:3], next_spd, wdata[B_ROLE_EN]};

  // control fields
  wire rs_allow = ctrl[B_RS];
  wire role_en = ctrl[B_ROLE_EN];
  wire sd = ctrl[B_SD];
  wire slv_wide = ctrl[B_RESP_WIDE];
  wire mst_w = LIVE_TGT ? tgt[B_TIM] : ctrl[B_INIT_WIDE];

  // role decode
  i2crc_role_t role;
  assign role = (!sd && !role_en) ? ROLE_SLAVE : (sd && role_en) ? ROLE_MASTER : ROLE_ERR;
  wire master_ok = enable && role == ROLE_MASTER;
  wire slave_ok = enable && role == ROLE_SLAVE;

  // register writes
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctrl <= CTRL_RST;
      tgt <= {3'h0, ADDR_RST};
      own <= ADDR_RST;
      enable <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= next_ctrl;
      end
      if (wr_tgt) begin
        tgt <= wdata[12:0];
      end
      if (wr_own && !enable) begin
        own <= wdata[9:0];
      end
      if (wr_ena) begin
        enable <= wdata[0];
      end
    end
  end

  // ------------------------------------------------------------
  // master command check
  // ------------------------------------------------------------
  wire cmd_rd = wdata[B_RD];
  wire is_bcast = tgt[B_SPECIAL] && !tgt[B_BCAST_SEL];
  wire is_sb = tgt[B_SPECIAL] && tgt[B_BCAST_SEL];
  wire dir_chg = open && cmd_rd != last_rd;
  wire need_rs = open && (dir_chg || wdata[B_RST]);
  wire rs_only = is_sb || (mst_w && cmd_rd);
  wire ab_rs = !rs_allow && rs_only;
  wire ab_bcast = is_bcast && cmd_rd;
  wire ab_self = !cmd_rd && !tgt[B_SPECIAL] && tgt[9:0] == own;
  wire cmd_abort = master_ok && cmd_wr && (ab_rs || ab_bcast || ab_self);
  wire cmd_ok = master_ok && cmd_wr && !cmd_abort;
  wire next_go = cmd_ok && (!open || need_rs);
  wire [9:0] next_addr = is_bcast ? 10'h000 : tgt[9:0];
  i2crc_kind_t next_kind;
  assign next_kind = is_bcast ? KIND_BCAST : is_sb ? KIND_SBYTE : KIND_NORM;

  // master address phase requests
  always_ff @(posedge clock) begin
    if (!nrst) begin
      mst_go <= 1'b0;
      mst_restart <= 1'b0;
      mst_addr <= ADDR_RST;
      mst_wide <= 1'b0;
      mst_read <= 1'b0;
      mst_kind <= KIND_NORM;
    end else begin
      mst_go <= next_go;
      if (next_go) begin
        mst_restart <= open && rs_allow;
        mst_addr <= next_addr;
        mst_wide <= mst_w && !is_bcast;
        mst_read <= cmd_rd;
        mst_kind <= next_kind;
      end
    end
  end

  // data commands and transfer tracking
  always_ff @(posedge clock) begin
    if (!nrst) begin
      mst_push <= 1'b0;
      mst_data <= 8'h00;
      mst_stop <= 1'b0;
      open <= 1'b0;
      last_rd <= 1'b0;
    end else begin
      mst_push <= cmd_ok;
      if (cmd_ok) begin
        mst_data <= wdata[7:0];
        mst_stop <= wdata[B_STOP];
        open <= !wdata[B_STOP];
        last_rd <= cmd_rd;
      end else if (cmd_abort || !master_ok) begin
        open <= 1'b0;
      end
    end
  end

  // abort flag: set wins over write-one clear
  always_ff @(posedge clock) begin
    if (!nrst) begin
      abort <= 1'b0;
    end else if (cmd_abort) begin
      abort <= 1'b1;
    end else if (wr_raw && wdata[B_ABRT]) begin
      abort <= 1'b0;
    end
  end

  assign mst_speed = ctrl[B_SPD+1:B_SPD];

  // ------------------------------------------------------------
  // register read
  // ------------------------------------------------------------
  wire [10:0] ctrl_view = {ctrl[10:5], mst_w, ctrl[3:0]};
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0;
    case (addr)
      A_CTRL: next_rdata = {21'h0, ctrl_view};
      A_TGT: next_rdata = {19'h0, tgt};
      A_OWN: next_rdata = {22'h0, own};
      A_RAW: next_rdata = {25'h0, abort, 6'h0};
      A_ENA: next_rdata = {31'h0, enable};
      default: next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdata <= 32'h0;
    end else begin
      rdata <= rd ? next_rdata : 32'h0;
    end
  end

  // ------------------------------------------------------------
  // link sampling and slave address match
  // ------------------------------------------------------------
  logic [1:0] scl_sy;
  logic [1:0] sda_sy;
  logic scl_q;
  logic sda_q;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      scl_sy <= 2'h3;
      sda_sy <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_sy <= {scl_sy[0], scl_in};
      sda_sy <= {sda_sy[0], sda_in};
      scl_q <= scl_sy[1];
      sda_q <= sda_sy[1];
    end
  end

  wire scl_s = scl_sy[1];
  wire sda_s = sda_sy[1];
  wire bus_start = scl_s && scl_q && sda_q && !sda_s;
  wire bus_stop = scl_s && scl_q && !sda_q && sda_s;
  wire scl_rise = scl_s && !scl_q;
  wire scl_fall = !scl_s && scl_q;
  i2crc_sl_t sl_st;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic second;
  logic ack_more;
  // address byte match
  wire hi_ok = shreg[7:3] == WIDE_HDR && shreg[2:1] == own[9:8] && !shreg[0];
  wire first_hit = slv_wide ? hi_ok : shreg[7:1] == own[6:0];
  wire second_hit = shreg == own[7:0];
  wire byte_hit = slave_ok && (second ? second_hit : first_hit);
  wire byte_end = sl_st == SL_SHIFT && scl_fall && bitcnt == BYTE_BITS;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sl_st <= SL_IDLE;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      second <= 1'b0;
      ack_more <= 1'b0;
      sda_oe <= 1'b0;
      slv_hit <= 1'b0;
      slv_read <= 1'b0;
    end else begin
      slv_hit <= 1'b0;
      if (bus_start) begin
        sl_st <= SL_SHIFT;
        bitcnt <= 4'h0;
        second <= 1'b0;
        sda_oe <= 1'b0;
      end else if (bus_stop) begin
        sl_st <= SL_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (sl_st)
          SL_SHIFT: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
            end else if (byte_end) begin
              sl_st <= byte_hit ? SL_ACK : SL_SKIP;
              sda_oe <= byte_hit;
              ack_more <= slv_wide && !second;
              slv_hit <= byte_hit && !(slv_wide && !second);
              if (!second) begin
                slv_read <= shreg[0];
              end
            end
          end
          SL_ACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              sl_st <= ack_more ? SL_SHIFT : SL_SKIP;
              second <= ack_more;
              bitcnt <= 4'h0;
            end
          end
          SL_IDLE, SL_SKIP: sda_oe <= 1'b0;
          default: sl_st <= SL_IDLE;
        endcase
      end
    end
  end

  assign sda_out = 1'b0; // open drain: only pulls low

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_spd_legal;
    mst_speed == SPD_STD || mst_speed == SPD_FAST;
  endproperty
  a_spd_legal: assert property (p_spd_legal) else $error("illegal speed held");
  property p_spd_fix;
    wr_ctrl && !spd_ok |=> mst_speed == SPD_FAST;
  endproperty
  a_spd_fix: assert property (p_spd_fix) else $error("illegal speed not replaced");
  property p_own_lock;
    wr_own && enable |=> $stable(own);
  endproperty
  a_own_lock: assert property (p_own_lock) else $error("own address changed while enabled");
  property p_no_go_err;
    cmd_wr && role == ROLE_ERR |=> !mst_go && !mst_push;
  endproperty
  a_no_go_err: assert property (p_no_go_err) else $error("master started in config error");
  property p_ack_slave;
    $rose(sda_oe) |-> $past(slave_ok);
  endproperty
  a_ack_slave: assert property (p_ack_slave) else $error("ack outside slave role");
  property p_bcast_read;
    cmd_wr && master_ok && is_bcast && cmd_rd |=> abort && !mst_go;
  endproperty
  a_bcast_read: assert property (p_bcast_read) else $error("general call read not aborted");
  property p_rs_abort;
    cmd_wr && master_ok && !rs_allow && is_sb |=> abort && !mst_push;
  endproperty
  a_rs_abort: assert property (p_rs_abort) else $error("start byte without restart not aborted");
  property p_split;
    mst_go && !rs_allow |-> !mst_restart;
  endproperty
  a_split: assert property (p_split) else $error("restart issued while forbidden");
  property p_bcast_addr;
    mst_go && mst_kind == KIND_BCAST |-> mst_addr == 10'h000 && !mst_read;
  endproperty
  a_bcast_addr: assert property (p_bcast_addr) else $error("general call carries target");
  // a clear write may follow at once, so only the cycle after the command is checked
  property p_self;
    cmd_wr && master_ok && !cmd_rd && !tgt[B_SPECIAL] && tgt[9:0] == own |=> abort && !mst_push;
  endproperty
  a_self: assert property (p_self) else $error("master wrote to itself");
  property p_cv_restart;
    mst_go && mst_restart;
  endproperty
  c_restart: cover property (p_cv_restart);
  property p_cv_hit;
    slv_hit ##[1:200] !sda_oe;
  endproperty
  c_hit: cover property (p_cv_hit);
  property p_cv_abort;
    $rose(abort);
  endproperty
  c_abort: cover property (p_cv_abort);
  property p_cv_bcast;
    mst_go && mst_kind == KIND_BCAST;
  endproperty
  c_bcast: cover property (p_cv_bcast);
endmodule

// ---- core/i2crc_pkg.sv ----
// Purpose: constants and types shared by the role and addressing block
// Assumes: one 125 MHz clock, word-aligned byte offsets
// Notes: control, enable, command and raw status bits live at fixed offsets
package i2crc_pkg;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_TGT = 8'h04;
  localparam logic [7:0] A_OWN = 8'h08;
  localparam logic [7:0] A_CMD = 8'h10;
  localparam logic [7:0] A_RAW = 8'h34;
  localparam logic [7:0] A_ENA = 8'h6c;
  // values after reset
  localparam logic [10:0] CTRL_RST = 11'h0e4;
  localparam logic [9:0] ADDR_RST = 10'h055;
  // control field positions
  localparam int B_ROLE_EN = 0;
  localparam int B_SPD = 1;
  localparam int B_RESP_WIDE = 3;
  localparam int B_INIT_WIDE = 4;
  localparam int B_RS = 5;
  localparam int B_SD = 6;
  // target field positions
  localparam int B_BCAST_SEL = 10;
  localparam int B_SPECIAL = 11;
  localparam int B_TIM = 12;
  // command field positions
  localparam int B_RD = 8;
  localparam int B_STOP = 9;
  localparam int B_RST = 10;
  // raw status field position
  localparam int B_ABRT = 6;
  // speed codes
  localparam logic [1:0] SPD_STD = 2'h1;
  localparam logic [1:0] SPD_FAST = 2'h2;
  // leading pattern of a wide address byte
  localparam logic [4:0] WIDE_HDR = 5'h1e;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  typedef enum logic [1:0] {ROLE_SLAVE, ROLE_MASTER, ROLE_ERR} i2crc_role_t;
  typedef enum logic [1:0] {KIND_NORM, KIND_BCAST, KIND_SBYTE} i2crc_kind_t;
  typedef enum logic [1:0] {SL_IDLE, SL_SHIFT, SL_ACK, SL_SKIP} i2crc_sl_t;
endpackage

// ---- bench/i2crc_remote.sv ----
// Purpose: remote two-wire master that sends address frames to the block
// Assumes: data line has a pull-up, so a released line reads high
// Notes: clock line idles high between frames; bit slots are 64 ns
`timescale 1ns/1ns
module i2crc_remote (
  input wire logic sda_wire, // resolved data line level
  output logic scl, // clock line drive
  output logic sda_rel // 1 releases the data line
);
  // ------------------------------
  // idle levels and bit slots
  // ------------------------------
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // one bit slot, line level sampled late in the high phase
  task automatic slot(input logic b, output logic seen);
    #16 sda_rel = b;
    #16 scl = 1'b1;
    #28 seen = sda_wire;
    #4 scl = 1'b0;
  endtask
  // start, bytes msb first with an ack slot each, stop; quits after a nack
  task automatic frame(input logic [15:0] bytes, input int n, output logic [31:0] acks);
    logic s;
    acks = 0;
    sda_rel = 1'b0;
    #32 scl = 1'b0;
    for (int k = 0; k < n; k++) begin
      for (int i = 15; i >= 8; i--) slot(bytes[i - 8 * k], s);
      slot(1'b1, s);
      if (s !== 1'b0) break;
      acks++;
    end
    #16 sda_rel = 1'b0;
    #16 scl = 1'b1;
    #16 sda_rel = 1'b1;
    #32;
  endtask
endmodule

// ---- bench/i2crc_test.sv ----
// Purpose: self-checking bench for role decode, master addressing and slave match
// Assumes: registers reached by single-cycle strobes, remote master on the link
// Notes: plain rows first, then master commands, slave frames and a second reset
`timescale 1ns/1ns
module i2crc_test;
  import i2crc_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic mst_go, mst_restart, mst_wide, mst_read, mst_push, mst_stop, slv_hit, slv_read, sda_out, sda_oe;
  logic [9:0] mst_addr;
  logic [7:0] mst_data;
  logic [1:0] mst_speed;
  i2crc_kind_t mst_kind;
  logic scl, sda_rel, sda_w;
  logic [31:0] acks;
  logic last_rd = 1'b0;
  int fails = 0;
  int checked = 0;
  int hits = 0;
  // write data, then read address and expected word
  logic [79:0] rows [9] = '{
    {A_CTRL, 32'h0, A_CTRL, 32'h4}, {A_CTRL, 32'h6, A_CTRL, 32'h4}, {A_CTRL, 32'ha, A_CTRL, 32'ha},
    {A_TGT, 32'h1abc, A_CTRL, 32'h1a}, {A_OWN, 32'h3ff, A_TGT, 32'h1abc}, {A_ENA, 32'h1, A_OWN, 32'h3ff},
    {A_OWN, 32'h11, A_OWN, 32'h3ff}, {8'h20, 32'hffff, 8'h20, 32'h0}, {A_CTRL, 32'h65, A_CTRL, 32'h75}};

  i2crc_top i2crc_top_inst (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .mst_go(mst_go), .mst_restart(mst_restart), .mst_addr(mst_addr), .mst_wide(mst_wide),
    .mst_read(mst_read), .mst_kind(mst_kind), .mst_push(mst_push), .mst_data(mst_data), .mst_stop(mst_stop),
    .mst_speed(mst_speed), .slv_hit(slv_hit), .slv_read(slv_read), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe));
  i2crc_remote i2crc_remote_inst (.sda_wire(sda_w), .scl(scl), .sda_rel(sda_rel));

  // open-drain data line with pull-up
  assign sda_w = sda_rel & ~(sda_oe & ~sda_out);
  always #4 clock = ~clock;
  // count address matches, keep the direction of the last one
  always @(posedge clock) begin
    if (slv_hit === 1'b1) begin
      hits <= hits + 1;
      last_rd <= slv_read;
    end
  end

  // ------------------------------
  // bus and compare tasks
  // ------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // command write; e is go, push, restart, kind; ab is the expected abort flag
  task automatic cmd(input logic [31:0] d, input logic [4:0] e, input logic ab);
    wr_reg(A_CMD, d);
    #1 chk(e[4] ? {mst_go, mst_push, mst_restart, mst_kind} : {mst_go, mst_push, 3'h0}, e);
    rd_reg(A_RAW, ab ? 32'h40 : 32'h0);
    wr_reg(A_RAW, 32'h40);
  endtask
  task automatic link(input logic [15:0] b, input int n, input logic [31:0] exp);
    i2crc_remote_inst.frame(b, n, acks);
    chk(acks, exp);
  endtask
  task automatic finish_test();
    $display("counts: %0d checked, %0d failed", checked, fails);
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial begin
    #400000;
    fails++;
    finish_test();
  end

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      wr_reg(rows[i][79:72], rows[i][71:40]);
      rd_reg(rows[i][39:32], rows[i][31:0]);
    end
    $display("register rows done");
    wr_reg(A_TGT, 32'h1133);
    chk(mst_speed, SPD_FAST);
    cmd(32'h100, 5'h18, 1'b0);
    chk({mst_wide, mst_read, mst_addr}, {2'h3, 10'h133});
    cmd(32'h600, 5'h1c, 1'b0);
    wr_reg(A_CTRL, 32'h45);
    cmd(32'h000, 5'h18, 1'b0);
    cmd(32'h600, 5'h18, 1'b0);
    cmd(32'h100, 5'h00, 1'b1);
    wr_reg(A_TGT, 32'hc33);
    cmd(32'h201, 5'h00, 1'b1);
    wr_reg(A_CTRL, 32'h65);
    cmd(32'h201, 5'h1a, 1'b0);
    wr_reg(A_TGT, 32'h833);
    cmd(32'h201, 5'h19, 1'b0);
    chk(mst_addr, 10'h000);
    cmd(32'h300, 5'h00, 1'b1);
    cmd(32'h201, 5'h19, 1'b0);
    wr_reg(A_TGT, 32'h433);
    cmd(32'h201, 5'h18, 1'b0);
    chk({mst_stop, mst_data, mst_addr}, {1'b1, 8'h01, 10'h033});
    wr_reg(A_TGT, 32'h3ff);
    cmd(32'h201, 5'h00, 1'b1);
    wr_reg(A_CTRL, 32'h25);
    cmd(32'h201, 5'h00, 1'b0);
    $display("master commands done");
    wr_reg(A_ENA, 32'h0);
    wr_reg(A_OWN, 32'h2da);
    wr_reg(A_CTRL, 32'h2);
    wr_reg(A_ENA, 32'h1);
    chk(mst_speed, SPD_STD);
    link(16'hb400, 1, 1);
    link(16'hb500, 1, 1);
    chk(last_rd, 1'b1);
    link(16'hb600, 1, 0);
    wr_reg(A_CTRL, 32'ha);
    link(16'hf4da, 2, 2);
    link(16'hf4db, 2, 1);
    link(16'hb400, 1, 0);
    wr_reg(A_CTRL, 32'h42);
    link(16'hb400, 1, 0);
    chk(hits, 3);
    $display("slave frames done");
    @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    #1 chk(mst_addr, ADDR_RST);
    rd_reg(A_CTRL, 32'he4);
    rd_reg(A_TGT, 32'h55);
    rd_reg(A_OWN, 32'h55);
    rd_reg(A_ENA, 32'h0);
    $display("reset values done");
    finish_test();
  end
endmodule
